// ==== ovr_params.svh ====
`ifndef OVR_PARAMS_SVH
`define OVR_PARAMS_SVH

// ***********************************************************
// register map: page and address
// ***********************************************************
`define OVR_PAGE_ANALOG    8'h01
`define OVR_PAGE_DIGITAL   8'h00
`define OVR_ADDR_ROUTE     8'h23
`define OVR_ADDR_LVOL      8'h24
`define OVR_ADDR_RVOL      8'h25
`define OVR_ADDR_STEP      8'h3f

// ***********************************************************
// field positions
// ***********************************************************
`define OVR_LDAC_BIT       6
`define OVR_RDAC_BIT       2
`define OVR_PA_BIT         7
`define OVR_CODE_MSB       6
`define OVR_STEP_MSB       1

// ***********************************************************
// reset values
// ***********************************************************
`define OVR_ROUTE_RST      8'h00
`define OVR_VOL_RST        8'h7f
`define OVR_STEP_RST       8'h00
`define OVR_CODE_RST       7'h7f
`define OVR_CODE_MUTE      7'h7f
`define OVR_ATTEN_RST      10'h30f
`define OVR_RDATA_RST      8'h00

// ***********************************************************
// soft-step timing
// ***********************************************************
`define OVR_CLK_NS         10
`define OVR_STEP_SAMPLE_NS 20833
`define OVR_STEP0_CYC      (`OVR_STEP_SAMPLE_NS / `OVR_CLK_NS)
`define OVR_STEP1_CYC      ((2 * `OVR_STEP_SAMPLE_NS) / `OVR_CLK_NS)

`endif

// ==== ovr_pkg.sv ====
package ovr_pkg;

   // stepper states
   typedef enum logic [0:0] {
      OVR_IDLE = 1'b0,
      OVR_WAIT = 1'b1
   } ovr_step_state_t;

   // soft-step interval selection
   typedef enum logic [1:0] {
      OVR_STEP_ONE  = 2'b00,
      OVR_STEP_TWO  = 2'b01,
      OVR_STEP_JUMP = 2'b10,
      OVR_STEP_RSV  = 2'b11
   } ovr_step_mode_t;

endpackage

// ==== ovr_soft_stepper.sv ====
`timescale 1ns/1ns
`include "ovr_params.svh"

module ovr_soft_stepper (
   // clock and reset
   input  wire logic                     clk,
   input  wire logic                     nrst,
   // control
   input  wire logic [6:0]               target,
   input  wire ovr_pkg::ovr_step_mode_t  mode,
   input  wire logic [12:0]              int0_cyc,
   input  wire logic [12:0]              int1_cyc,
   // applied state
   output logic [6:0]                    code_q,
   output logic                          busy_q
);

   ovr_pkg::ovr_step_state_t state_q;
   ovr_pkg::ovr_step_state_t state_d;
   logic [6:0]               code_d;
   logic [12:0]              cnt_q;
   logic [12:0]              cnt_d;
   logic [12:0]              interval;
   logic [6:0]               next_code;

   // ***********************************************************
   // step sequencer
   // ***********************************************************

   // interval select and one-code move
   always_comb begin
      interval  = (mode == ovr_pkg::OVR_STEP_TWO) ? int1_cyc : int0_cyc;
      next_code = (code_q < target) ? code_q + 7'h01 : code_q - 7'h01;
   end

   // next state, code and counter
   always_comb begin
      state_d = state_q;
      code_d  = code_q;
      cnt_d   = cnt_q;
      case (state_q)
         ovr_pkg::OVR_IDLE: begin
            if (code_q != target) begin
               if (mode == ovr_pkg::OVR_STEP_JUMP) begin
                  code_d = target;
               end else begin
                  // RL7 gradual move start
                  cnt_d   = interval - 13'h0001;
                  state_d = ovr_pkg::OVR_WAIT;
               end
            end
         end
         ovr_pkg::OVR_WAIT: begin
            if (code_q == target) begin
               state_d = ovr_pkg::OVR_IDLE;
            end else if (cnt_q == 13'h0000) begin
               // RL13 one code per interval
               code_d = next_code;
               cnt_d  = interval - 13'h0001;
               if (next_code == target) begin
                  state_d = ovr_pkg::OVR_IDLE;
               end
            end else begin
               cnt_d = cnt_q - 13'h0001;
            end
         end
         default: begin
            state_d = ovr_pkg::OVR_IDLE;
         end
      endcase
   end

   // registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= ovr_pkg::OVR_IDLE;
         code_q  <= `OVR_CODE_RST;
         cnt_q   <= 13'h0000;
         busy_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         code_q  <= code_d;
         cnt_q   <= cnt_d;
         busy_q  <= (state_d == ovr_pkg::OVR_WAIT);
      end
   end

   // ***********************************************************
   // checks
   // ***********************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence code_moved_s;
      code_q != $past(code_q);
   endsequence

   // RL13 single code steps
   step_size_a: assert property (code_moved_s and ($past(mode) != ovr_pkg::OVR_STEP_JUMP) |-> // RL13
      (code_q == $past(code_q) + 7'h01) || (code_q == $past(code_q) - 7'h01))
      else $error("soft step moved more than one code");

   // RL7 step waits for interval
   step_wait_a: assert property (($past(state_q) == ovr_pkg::OVR_WAIT) and code_moved_s |-> // RL7
      $past(cnt_q) == 13'h0000)
      else $error("code stepped before interval expired");

   // RL13 stops at target
   hold_target_a: assert property (state_q == ovr_pkg::OVR_IDLE && code_q == target // RL13
      && $stable(target) |=> $stable(code_q))
      else $error("code moved while at target");

endmodule // ovr_soft_stepper

// ==== ovr_volume_ctrl.sv ====
// Contract
// RL1: bit 6 of the routing register connects the left DAC output to the left volume stage.
// RL2: bit 2 of the routing register connects the right DAC output to the right volume stage.
// RL3: bits 6-0 of the left volume register hold the left attenuation code.
// RL4: bits 6-0 of the right volume register hold the right attenuation code.
// RL5: bit 7 of the left volume register routes the left stage into the left headphone amplifier.
// RL6: bit 7 of the right volume register routes the right stage into the right headphone amplifier.
// RL7: a changed code is reached gradually in soft steps, not at once; step mode 2'b10 (jump) applies it at once. Logic jumps only from idle, not mid-run.
// RL8: bits 1-0 of the step timing register select the interval between steps.
// RL9: codes map to 0 dB down to -78.3 dB, 0.5 dB per code low, a table deeper, 117-127 all -78.3 dB.
// RL10: a channel is muted when its amplifier routing bit is 0 and its code is 127.
// RL11: each channel keeps its own gain and both apply different levels at once.
// RL12: volume and soft stepping keep working while the DAC is powered down.
// RL13: the applied code moves one code per interval toward the target and stops there; in jump mode it takes the target at once. Logic jumps only from idle.
`timescale 1ns/1ns
`include "ovr_params.svh"

module ovr_volume_ctrl #(
   parameter logic [12:0] STEP0_CYC = 13'(`OVR_STEP0_CYC),
   parameter logic [12:0] STEP1_CYC = 13'(`OVR_STEP1_CYC)
) (
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        NRST,
   // register access port
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   input  wire logic [7:0]  REG_PAGE,
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic [7:0]  REG_WDATA,
   output logic [7:0]       REG_RDATA,
   output logic             REG_RVALID,
   // routing controls
   output logic             HPL_DAC_ROUTE,
   output logic             HPR_DAC_ROUTE,
   output logic             HPL_PA_ROUTE,
   output logic             HPR_PA_ROUTE,
   // applied volume, left
   output logic [6:0]       HPL_CODE,
   output logic [9:0]       HPL_ATTEN,
   output logic             HPL_MUTE,
   output logic             HPL_BUSY,
   // applied volume, right
   output logic [6:0]       HPR_CODE,
   output logic [9:0]       HPR_ATTEN,
   output logic             HPR_MUTE,
   output logic             HPR_BUSY
);

   // ***********************************************************
   // attenuation map, tenths of a dB
   // ***********************************************************

   // RL9 code to attenuation
   function automatic logic [9:0] atten_map(input logic [6:0] c);
      logic [9:0] cw;
      logic [9:0] r;
      cw = {3'h0, c};
      if (c < 7'h24) begin
         r = cw * 10'h005;
      end else if (c < 7'h3c) begin
         r = 10'h0b5 + (cw - 10'h024) * 10'h005;
      end else if (c < 7'h46) begin
         r = 10'h12d + (cw - 10'h03c) * 10'h005;
      end else if (c < 7'h54) begin
         r = 10'h160 + (cw - 10'h046) * 10'h005;
      end else begin
         case (c)
            7'h54: r = 10'h1a5;
            7'h55: r = 10'h1ab;
            7'h56: r = 10'h1b0;
            7'h57: r = 10'h1b6;
            7'h58: r = 10'h1bb;
            7'h59: r = 10'h1c0;
            7'h5a: r = 10'h1c4;
            7'h5b: r = 10'h1ca;
            7'h5c: r = 10'h1ce;
            7'h5d: r = 10'h1d3;
            7'h5e: r = 10'h1da;
            7'h5f: r = 10'h1df;
            7'h60: r = 10'h1e2;
            7'h61: r = 10'h1e7;
            7'h62: r = 10'h1ed;
            7'h63: r = 10'h1f4;
            7'h64: r = 10'h1f7;
            7'h65: r = 10'h1fe;
            7'h66: r = 10'h202;
            7'h67: r = 10'h206;
            7'h68: r = 10'h20a;
            7'h69: r = 10'h20f;
            7'h6a: r = 10'h219;
            7'h6b: r = 10'h21e;
            7'h6c: r = 10'h229;
            7'h6d: r = 10'h237;
            7'h6e: r = 10'h247;
            7'h6f: r = 10'h25a;
            7'h70: r = 10'h273;
            7'h71: r = 10'h283;
            7'h72: r = 10'h296;
            7'h73: r = 10'h2af;
            7'h74: r = 10'h2d2;
            default: r = 10'h30f; // floor for 117-127
         endcase
      end
      return r;
   endfunction

   // register hit on page and address
   function automatic logic reg_hit(input logic [7:0] pg, input logic [7:0] ad);
      return (REG_PAGE == pg) && (REG_ADDR == ad);
   endfunction

   // ***********************************************************
   // register file
   // ***********************************************************
   logic [7:0] route_q;
   logic [7:0] route_d;
   logic [7:0] lvol_q;
   logic [7:0] lvol_d;
   logic [7:0] rvol_q;
   logic [7:0] rvol_d;
   logic [7:0] step_q;
   logic [7:0] step_d;
   logic [7:0] rdata_d;

   // write decode and read mux
   always_comb begin
      route_d = route_q;
      lvol_d  = lvol_q;
      rvol_d  = rvol_q;
      step_d  = step_q;
      rdata_d = REG_RDATA;
      if (REG_WR) begin
         if (reg_hit(`OVR_PAGE_ANALOG, `OVR_ADDR_ROUTE)) begin
            route_d = REG_WDATA;
         end
         if (reg_hit(`OVR_PAGE_ANALOG, `OVR_ADDR_LVOL)) begin
            lvol_d = REG_WDATA;
         end
         if (reg_hit(`OVR_PAGE_ANALOG, `OVR_ADDR_RVOL)) begin
            rvol_d = REG_WDATA;
         end
         if (reg_hit(`OVR_PAGE_DIGITAL, `OVR_ADDR_STEP)) begin
            step_d = REG_WDATA;
         end
      end
      if (REG_RD) begin
         if (reg_hit(`OVR_PAGE_ANALOG, `OVR_ADDR_ROUTE)) begin
            rdata_d = route_q;
         end else if (reg_hit(`OVR_PAGE_ANALOG, `OVR_ADDR_LVOL)) begin
            rdata_d = lvol_q;
         end else if (reg_hit(`OVR_PAGE_ANALOG, `OVR_ADDR_RVOL)) begin
            rdata_d = rvol_q;
         end else if (reg_hit(`OVR_PAGE_DIGITAL, `OVR_ADDR_STEP)) begin
            rdata_d = step_q;
         end else begin
            rdata_d = `OVR_RDATA_RST; // unmapped reads zero
         end
      end
   end

   // register storage
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         route_q    <= `OVR_ROUTE_RST;
         lvol_q     <= `OVR_VOL_RST;
         rvol_q     <= `OVR_VOL_RST;
         step_q     <= `OVR_STEP_RST;
         REG_RDATA  <= `OVR_RDATA_RST;
         REG_RVALID <= 1'b0;
      end else begin
         route_q    <= route_d;
         lvol_q     <= lvol_d;
         rvol_q     <= rvol_d;
         step_q     <= step_d;
         REG_RDATA  <= rdata_d;
         REG_RVALID <= REG_RD;
      end
   end

   // ***********************************************************
   // soft steppers, one per channel
   // ***********************************************************
   logic [6:0]             lcode;
   logic [6:0]             rcode;
   logic                   lbusy;
   logic                   rbusy;
   ovr_pkg::ovr_step_mode_t step_mode;

   // RL8 interval select field
   assign step_mode = ovr_pkg::ovr_step_mode_t'(step_q[`OVR_STEP_MSB:0]);

   // RL11 independent left stage
   // RL12 no dependence on DAC power
   ovr_soft_stepper u_step_l (
      .clk      (CLK),
      .nrst     (NRST),
      .target   (lvol_q[`OVR_CODE_MSB:0]),
      .mode     (step_mode),
      .int0_cyc (STEP0_CYC),
      .int1_cyc (STEP1_CYC),
      .code_q   (lcode),
      .busy_q   (lbusy)
   );

   // RL11 independent right stage
   ovr_soft_stepper u_step_r (
      .clk      (CLK),
      .nrst     (NRST),
      .target   (rvol_q[`OVR_CODE_MSB:0]),
      .mode     (step_mode),
      .int0_cyc (STEP0_CYC),
      .int1_cyc (STEP1_CYC),
      .code_q   (rcode),
      .busy_q   (rbusy)
   );

   // ***********************************************************
   // output stage
   // ***********************************************************
   logic       ldac_d;
   logic       rdac_d;
   logic       lpa_d;
   logic       rpa_d;
   logic [9:0] latten_d;
   logic [9:0] ratten_d;
   logic       lmute_d;
   logic       rmute_d;

   // next output values
   always_comb begin
      // RL1 left DAC routing
      ldac_d   = route_q[`OVR_LDAC_BIT];
      // RL2 right DAC routing
      rdac_d   = route_q[`OVR_RDAC_BIT];
      // RL5 left amplifier routing
      lpa_d    = lvol_q[`OVR_PA_BIT];
      // RL6 right amplifier routing
      rpa_d    = rvol_q[`OVR_PA_BIT];
      // RL3 left code applied
      latten_d = atten_map(lcode);
      // RL4 right code applied
      ratten_d = atten_map(rcode);
      // RL10 mute decode
      lmute_d  = !lvol_q[`OVR_PA_BIT] && (lcode == `OVR_CODE_MUTE);
      rmute_d  = !rvol_q[`OVR_PA_BIT] && (rcode == `OVR_CODE_MUTE);
   end

   // output flops
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         HPL_DAC_ROUTE <= 1'b0;
         HPR_DAC_ROUTE <= 1'b0;
         HPL_PA_ROUTE  <= 1'b0;
         HPR_PA_ROUTE  <= 1'b0;
         HPL_CODE      <= `OVR_CODE_RST;
         HPR_CODE      <= `OVR_CODE_RST;
         HPL_ATTEN     <= `OVR_ATTEN_RST;
         HPR_ATTEN     <= `OVR_ATTEN_RST;
         HPL_MUTE      <= 1'b1;
         HPR_MUTE      <= 1'b1;
         HPL_BUSY      <= 1'b0;
         HPR_BUSY      <= 1'b0;
      end else begin
         HPL_DAC_ROUTE <= ldac_d;
         HPR_DAC_ROUTE <= rdac_d;
         HPL_PA_ROUTE  <= lpa_d;
         HPR_PA_ROUTE  <= rpa_d;
         HPL_CODE      <= lcode;
         HPR_CODE      <= rcode;
         HPL_ATTEN     <= latten_d;
         HPR_ATTEN     <= ratten_d;
         HPL_MUTE      <= lmute_d;
         HPR_MUTE      <= rmute_d;
         HPL_BUSY      <= lbusy;
         HPR_BUSY      <= rbusy;
      end
   end

   // ***********************************************************
   // checks
   // ***********************************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);

   sequence route_write_s;
      REG_WR && REG_PAGE == `OVR_PAGE_ANALOG && REG_ADDR == `OVR_ADDR_ROUTE;
   endsequence

   sequence lvol_write_s;
      REG_WR && REG_PAGE == `OVR_PAGE_ANALOG && REG_ADDR == `OVR_ADDR_LVOL;
   endsequence

   left_dac_route_a: assert property (route_write_s |-> ##2 HPL_DAC_ROUTE == $past(REG_WDATA[6], 2)) // RL1
      else $error("left DAC routing does not follow write");

   right_dac_route_a: assert property (route_write_s |-> ##2 HPR_DAC_ROUTE == $past(REG_WDATA[2], 2)) // RL2
      else $error("right DAC routing does not follow write");

   left_pa_route_a: assert property (lvol_write_s |-> ##2 HPL_PA_ROUTE == $past(REG_WDATA[7], 2)) // RL5
      else $error("left amplifier routing does not follow write");

   right_pa_route_a: assert property (REG_WR && REG_PAGE == `OVR_PAGE_ANALOG // RL6
      && REG_ADDR == `OVR_ADDR_RVOL |-> ##2 HPR_PA_ROUTE == $past(REG_WDATA[7], 2))
      else $error("right amplifier routing does not follow write");

   left_target_a: assert property (lvol_write_s ##1 !REG_WR [*2] |-> ##0 lvol_q[6:0] == $past(REG_WDATA[6:0], 2)) // RL3
      else $error("left code not stored");

   right_jump_a: assert property (step_mode == ovr_pkg::OVR_STEP_JUMP && rbusy == 1'b0 // RL4
      && $stable(rvol_q) && $stable(step_q) |-> ##2 HPR_CODE == $past(rvol_q[6:0], 2))
      else $error("right code not applied in jump mode");

   atten_floor_a: assert property ($past(lcode) > 7'h74 |-> HPL_ATTEN == 10'h30f) // RL9
      else $error("deep codes not at floor");

   atten_fine_a: assert property ($past(rcode) < 7'h24 |-> HPR_ATTEN == {3'h0, $past(rcode)} * 10'h005) // RL9
      else $error("fine range not half dB per code");

   left_mute_a: assert property (HPL_MUTE |-> $past(lcode) == 7'h7f && !$past(lvol_q[7])) // RL10
      else $error("mute without its condition");

endmodule // ovr_volume_ctrl

// ==== tb_output_volume_routing_control.sv ====
`timescale 1ns/1ns

module tb_output_volume_routing_control;
   // ***********************************************************
   // stimulus, instance and counters
   // ***********************************************************
   typedef struct {
      logic [7:0] rt;
      logic [7:0] lv;
      logic [7:0] rv;
      logic [9:0] la;
      logic [9:0] ra;
   } ovr_row_t;

   logic       CLK        = 1'h0;
   logic       NRST       = 1'h0;
   logic       REG_WR     = 1'h0;
   logic       REG_RD     = 1'h0;
   logic [7:0] REG_PAGE   = 8'h00;
   logic [7:0] REG_ADDR   = 8'h00;
   logic [7:0] REG_WDATA  = 8'h00;
   logic [7:0] REG_RDATA;
   logic       REG_RVALID;
   logic       HPL_DAC_ROUTE, HPR_DAC_ROUTE, HPL_PA_ROUTE, HPR_PA_ROUTE;
   logic [6:0] HPL_CODE, HPR_CODE;
   logic [9:0] HPL_ATTEN, HPR_ATTEN;
   logic       HPL_MUTE, HPR_MUTE, HPL_BUSY, HPR_BUSY;
   int         err_count  = 0;
   int         compares   = 0;
   ovr_row_t   rows [6];

   ovr_volume_ctrl #(.STEP0_CYC(13'h0004), .STEP1_CYC(13'h0008)) u_dut (
      .CLK(CLK), .NRST(NRST), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_PAGE(REG_PAGE),
      .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
      .HPL_DAC_ROUTE(HPL_DAC_ROUTE), .HPR_DAC_ROUTE(HPR_DAC_ROUTE), .HPL_PA_ROUTE(HPL_PA_ROUTE),
      .HPR_PA_ROUTE(HPR_PA_ROUTE), .HPL_CODE(HPL_CODE), .HPL_ATTEN(HPL_ATTEN), .HPL_MUTE(HPL_MUTE),
      .HPL_BUSY(HPL_BUSY), .HPR_CODE(HPR_CODE), .HPR_ATTEN(HPR_ATTEN), .HPR_MUTE(HPR_MUTE),
      .HPR_BUSY(HPR_BUSY)
   );

   // 100 MHz clock
   always #5 CLK = ~CLK;

   // ***********************************************************
   // bus cycles and compares
   // ***********************************************************
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // compare one value, widened to ten bits
   task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask

   // one-cycle write strobe
   task automatic wr(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] dt);
      @(posedge CLK);
      REG_WR    <= 1'h1;
      REG_PAGE  <= pg;
      REG_ADDR  <= ad;
      REG_WDATA <= dt;
      @(posedge CLK);
      REG_WR    <= 1'h0;
   endtask

   // one-cycle read strobe, data checked the cycle after
   task automatic rd(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] exp);
      @(posedge CLK);
      REG_RD   <= 1'h1;
      REG_PAGE <= pg;
      REG_ADDR <= ad;
      @(posedge CLK);
      REG_RD   <= 1'h0;
      #1;
      chk("rvalid", 10'h001, {9'h000, REG_RVALID});
      chk("rdata", {2'h0, exp}, {2'h0, REG_RDATA});
      @(posedge CLK);
      #1;
      chk("rvalid low", 10'h000, {9'h000, REG_RVALID});
   endtask

   // applied volume of both channels
   task automatic chk_vol(input logic [7:0] lv, input logic [9:0] la, input logic [7:0] rv,
                          input logic [9:0] ra);
      chk("left code", {3'h0, lv[6:0]}, {3'h0, HPL_CODE});
      chk("right code", {3'h0, rv[6:0]}, {3'h0, HPR_CODE});
      chk("left atten", la, HPL_ATTEN);
      chk("right atten", ra, HPR_ATTEN);
      chk("left pa", {9'h000, lv[7]}, {9'h000, HPL_PA_ROUTE});
      chk("right pa", {9'h000, rv[7]}, {9'h000, HPR_PA_ROUTE});
      chk("left mute", {9'h000, lv == 8'h7f}, {9'h000, HPL_MUTE});
      chk("right mute", {9'h000, rv == 8'h7f}, {9'h000, HPR_MUTE});
   endtask

   // soft-step run on the left channel, n cycles per code
   task automatic step_run(input logic [7:0] md, input logic [6:0] fc, input logic [6:0] tc, input int n);
      int         cnt;
      int         last;
      logic [6:0] prev;
      wr(8'h00, 8'h3f, 8'h02);
      wr(8'h01, 8'h24, {1'h1, fc});
      wait_cyc(6);
      wr(8'h00, 8'h3f, md);
      wr(8'h01, 8'h24, {1'h1, tc});
      cnt  = 0;
      last = 2;
      prev = fc;
      while (HPL_CODE !== tc && cnt < 400) begin
         @(posedge CLK);
         #1;
         cnt++;
         if (cnt == 3) chk("busy high", 10'h001, {9'h000, HPL_BUSY});
         if (cnt == 3) chk("right busy", 10'h000, {9'h000, HPR_BUSY});
         if (HPL_CODE !== prev) begin
            chk("step size", {3'h0, (tc > prev) ? prev + 7'h01 : prev - 7'h01}, {3'h0, HPL_CODE});
            chk("step gap", 10'(n), 10'(cnt - last));
            last = cnt;
            prev = HPL_CODE;
         end
      end
      chk("step end", {3'h0, tc}, {3'h0, HPL_CODE});
      chk("busy low", 10'h000, {9'h000, HPL_BUSY});
   endtask

   // ***********************************************************
   // main sequence
   // ***********************************************************
   initial begin
      rows[0] = '{8'h40, 8'h00, 8'h01, 10'h000, 10'h005};
      rows[1] = '{8'h04, 8'h23, 8'h24, 10'h0af, 10'h0b5};
      rows[2] = '{8'h44, 8'h74, 8'h75, 10'h2d2, 10'h30f};
      rows[3] = '{8'hbb, 8'h3c, 8'h63, 10'h12d, 10'h1f4};
      rows[4] = '{8'h00, 8'h7f, 8'hff, 10'h30f, 10'h30f};
      rows[5] = '{8'hff, 8'h9e, 8'h57, 10'h096, 10'h1b6};
      repeat (8) @(posedge CLK);
      NRST <= 1'h1;
      wait_cyc(1);
      chk_vol(8'h7f, 10'h30f, 8'h7f, 10'h30f);
      rd(8'h01, 8'h23, 8'h00);
      rd(8'h01, 8'h24, 8'h7f);
      rd(8'h01, 8'h25, 8'h7f);
      rd(8'h00, 8'h3f, 8'h00);
      // step register fully read back, upper bits kept, mode jump
      wr(8'h00, 8'h3f, 8'hfe);
      rd(8'h00, 8'h3f, 8'hfe);
      // table rows: routing, codes, gain map, mute, both channels at once
      foreach (rows[i]) begin
         wr(8'h01, 8'h23, rows[i].rt);
         wr(8'h01, 8'h24, rows[i].lv);
         wr(8'h01, 8'h25, rows[i].rv);
         wait_cyc(6);
         chk("left dac", {9'h000, rows[i].rt[6]}, {9'h000, HPL_DAC_ROUTE});
         chk("right dac", {9'h000, rows[i].rt[2]}, {9'h000, HPR_DAC_ROUTE});
         chk_vol(rows[i].lv, rows[i].la, rows[i].rv, rows[i].ra);
         rd(8'h01, 8'h23, rows[i].rt);
         rd(8'h01, 8'h24, rows[i].lv);
         rd(8'h01, 8'h25, rows[i].rv);
      end
      // unmapped places: writes dropped, reads give zero
      wr(8'h00, 8'h23, 8'h00);
      rd(8'h01, 8'h23, 8'hff);
      rd(8'h00, 8'h23, 8'h00);
      rd(8'h01, 8'h3f, 8'h00);
      rd(8'h01, 8'h26, 8'h00);
      // soft stepping in each stepping mode, up and down
      step_run(8'h00, 7'h10, 7'h0d, 4);
      step_run(8'h01, 7'h20, 7'h22, 8);
      step_run(8'h03, 7'h05, 7'h07, 4);
      // reset after the last run has ended returns applied volume to mute
      @(posedge CLK);
      NRST <= 1'h0;
      wait_cyc(2);
      chk_vol(8'h7f, 10'h30f, 8'h7f, 10'h30f);
      chk("left dac", 10'h000, {9'h000, HPL_DAC_ROUTE});
      @(posedge CLK);
      NRST <= 1'h1;
      rd(8'h01, 8'h24, 8'h7f);
      print_verdict();
   end

   // watchdog against a hang
   initial begin
      #300000;
      err_count++;
      print_verdict();
   end
endmodule // tb_output_volume_routing_control
